// File: logic/display_bus_output_port.sv
// display bus output port: axi4-lite registers, waveform generator, serializer
// Notes on behaviour
// R01 - four control lines, each with a freely programmable per-cycle waveform.
// R02 - each line: first level, second at first switch, third at second switch.
// R03 - waveforms only in output cycles; cycles run back to back while data waits.
// R04 - idle with no data and no read: each line shows its own quiescent level.
// R05 - normal mode: 32 steps per cycle, switch steps 0 to 31.
// R06 - short count: 16 steps; software keeps switch steps within 0 to 15.
// R07 - a line may be active only on even or only on odd cycles.
// R08 - even and odd allow bits default 1; clearing both silences the line.
// R09 - even/odd counter alternates every output cycle, idle does not restart it.
// R10 - while even-restart set next cycle is even; software clears it later.
// R11 - capture strobe loads input bus into input register on the clock edge.
// R12 - word serialized per width and mode, with low/high byte selects.
// R13 - read start runs exactly one cycle, capturing at the read strobe step.
// R14 - read start clears itself after that cycle; lines return to idle.
// R15 - read start clears read-valid; capture sets it; software polls it.
// R16 - software starts reads only with the write buffer empty.
// R17 - reads only with write disabled; enabled writes ignore read start.
// R18 - active-high interrupt on selected buffer status conditions.
// R19 - each output cycle is the module clock divided by 16 or 32.
// R20 - 8-bit shared data bus plus four lines; alternate function owns pins.
// R21 - 16-bit option extends the data bus with bits 15 to 8.
// R22 - tristate option floats bus when no write; else only during reads.
// R23 - 8-bit: 1, 2 or 4 bytes per word; 16-bit: 1 or 2 half-words.
// R24 - input register is 16 bits, holding the latest read capture.
// R25 - third level holds to cycle end; next cycle restarts at first level.
module display_bus_output_port (
    input  wire logic        clk,                 // 25 MHz module clock
    input  wire logic        srst,                // synchronous reset
    input  wire logic        ce,                  // clock enable, freezes all
    input  wire logic [5:0]  s_axi_awaddr,        // write address
    input  wire logic        s_axi_awvalid,       // write address valid
    output logic             s_axi_awready,       // write address ready
    input  wire logic [31:0] s_axi_wdata,         // write data
    input  wire logic [3:0]  s_axi_wstrb,         // byte enables
    input  wire logic        s_axi_wvalid,        // write data valid
    output logic             s_axi_wready,        // write data ready
    output logic [1:0]       s_axi_bresp,         // write response
    output logic             s_axi_bvalid,        // write response valid
    input  wire logic        s_axi_bready,        // write response ready
    input  wire logic [5:0]  s_axi_araddr,        // read address
    input  wire logic        s_axi_arvalid,       // read address valid
    output logic             s_axi_arready,       // read address ready
    output logic [31:0]      s_axi_rdata,         // read data
    output logic [1:0]       s_axi_rresp,         // read response
    output logic             s_axi_rvalid,        // read data valid
    input  wire logic        s_axi_rready,        // read data ready
    input  wire logic        alt_function_select, // pins owned by this port
    input  wire logic [15:0] din_pins,            // input data bus pins
    output disp_port_pkg::bus_out_t dout_bus,     // output data bus and enable
    output logic [3:0]       ctrl_lines,          // control lines three..zero
    output logic             low_byte_sel,        // low part driven
    output logic             high_byte_sel,       // high part driven
    output logic             port_irq             // interrupt request
);
    import disp_port_pkg::*;

    // ==================================================
    // registers
    line_cfg_t   cfg [4];
    logic [31:0] ctrl;
    logic [15:0] din_reg;
    logic        rd_valid;
    logic        push_err;
    logic [31:0] word;
    logic        held;
    logic [15:0] din_meta;
    logic [15:0] din_sync;
    logic        alt_meta;
    logic        alt_sync;

    port_state_t st;
    logic [4:0]  step;
    logic [1:0]  part;
    logic        parity;

    logic        aw_got;
    logic        w_got;
    logic [5:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    logic [4:0]  step_end;
    logic        last_step;
    logic [1:0]  last_part;
    logic        wr_fire;
    logic        ctrl_wr;
    logic [31:0] ctrl_new;
    logic        push_wr;

    always_comb begin
        step_end  = ctrl[CB_SHORT] ? STEP_END_SHORT : STEP_END_LONG; // R05 R06 R19
        last_step = (step == step_end);
        unique case ({ctrl[CB_WIDTH], ctrl[CB_MODE_LO+1 -: 2]}) // R23
            3'b001:  last_part = 2'd1;
            3'b010:  last_part = 2'd3;
            3'b101:  last_part = 2'd1;
            3'b110:  last_part = 2'd1;
            default: last_part = 2'd0;
        endcase
        wr_fire  = aw_got && w_got && !s_axi_bvalid;
        ctrl_wr  = wr_fire && (aw_addr == ADDR_CONTROL);
        push_wr  = wr_fire && (aw_addr == ADDR_DATA_OUT);
        for (int b = 0; b < 4; b++) begin
            ctrl_new[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : ctrl[b*8 +: 8];
        end
    end

    // ==================================================
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (srst) begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
            alt_meta <= 1'b0;
            alt_sync <= 1'b0;
        end else if (ce) begin
            din_meta <= din_pins;
            din_sync <= din_meta;
            alt_meta <= alt_function_select;
            alt_sync <= alt_meta;
        end
    end

    // ==================================================
    // axi4-lite write channel
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 6'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                aw_addr       <= {s_axi_awaddr[5:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr > ADDR_DATA_IN) ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            {cfg[1], cfg[0]} <= TIMING_RESET;
            {cfg[3], cfg[2]} <= TIMING_RESET;
        end else if (ce && wr_fire) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b] && aw_addr == ADDR_TIMING_01) begin
                    cfg[b/2][(b%2)*8 +: 8] <= w_data[b*8 +: 8]; // R01
                end
                if (w_strb[b] && aw_addr == ADDR_TIMING_23) begin
                    cfg[2+b/2][(b%2)*8 +: 8] <= w_data[b*8 +: 8]; // R01
                end
            end
        end
    end

    // read start self-clears at the end of its one cycle; a new write wins
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= CONTROL_RESET;
        end else if (ce) begin
            if (st == ST_READ && last_step) begin
                ctrl[CB_RD_START] <= 1'b0; // R14
            end
            if (ctrl_wr) begin
                ctrl <= {11'h000, ctrl_new[20:0]};
                ctrl[CB_CLR_PUSH] <= 1'b0;
            end
        end
    end

    // ==================================================
    // one-word write holding stage and its status
    always_ff @(posedge clk) begin
        if (srst) begin
            held     <= 1'b0;
            word     <= 32'h00000000;
            push_err <= 1'b0;
        end else if (ce) begin
            if (st == ST_WRITE && last_step && part == last_part) begin
                held <= 1'b0;
            end
            if (ctrl_wr && ctrl_new[CB_CLR_PUSH]) begin
                push_err <= 1'b0;
            end
            if (push_wr) begin
                if (held && !(st == ST_WRITE && last_step && part == last_part)) begin
                    push_err <= 1'b1; // a push onto a full stage is dropped
                end else begin
                    held <= 1'b1;
                    word <= w_data;
                end
            end
        end
    end

    // ==================================================
    // cycle sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            st   <= ST_IDLE;
            step <= 5'h00;
            part <= 2'd0;
        end else if (ce) begin
            unique case (st)
                ST_IDLE: begin
                    step <= 5'h00;
                    if (ctrl[CB_WR_EN] && held) begin
                        st <= ST_WRITE; // R03 R17
                    end else if (!ctrl[CB_WR_EN] && ctrl[CB_RD_START]) begin
                        st <= ST_READ; // R13 R16 R17
                    end
                end
                ST_WRITE: begin
                    step <= last_step ? 5'h00 : step + 5'h01; // R19
                    if (last_step) begin
                        part <= (part == last_part) ? 2'd0 : part + 2'd1; // R12
                        if (part == last_part && !push_wr) begin
                            st <= ST_IDLE; // R03
                        end
                    end
                end
                ST_READ: begin
                    step <= last_step ? 5'h00 : step + 5'h01;
                    if (last_step) begin
                        st <= ST_IDLE; // R14
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // parity keeps running across idle gaps
    always_ff @(posedge clk) begin
        if (srst) begin
            parity <= 1'b0;
        end else if (ce) begin
            if (st == ST_IDLE && ctrl[CB_RES_EVEN]) begin
                parity <= 1'b0; // R10
            end else if (st != ST_IDLE && last_step) begin
                parity <= ctrl[CB_RES_EVEN] ? 1'b0 : ~parity; // R09 R10
            end
        end
    end

    // ==================================================
    // input capture
    always_ff @(posedge clk) begin
        if (srst) begin
            din_reg  <= 16'h0000;
            rd_valid <= 1'b0;
        end else if (ce) begin
            if (st == ST_READ && step == ctrl[4:0]) begin
                din_reg  <= din_sync; // R11 R24
                rd_valid <= 1'b1; // R15
            end else if (ctrl_wr && ctrl_new[CB_RD_START]) begin
                rd_valid <= 1'b0; // R15
            end
        end
    end

    // ==================================================
    // waveform and bus outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_lines    <= 4'h0;
            dout_bus      <= '0;
            low_byte_sel  <= 1'b0;
            high_byte_sel <= 1'b0;
            port_irq      <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (st == ST_IDLE || !(parity ? cfg[i].odd_cycle_allow
                                              : cfg[i].even_cycle_allow)) begin
                    ctrl_lines[i] <= cfg[i].quiescent; // R04 R07 R08
                end else if (step < cfg[i].first_switch_step) begin
                    ctrl_lines[i] <= cfg[i].phase_a_level; // R02 R25
                end else if (step < cfg[i].second_switch_step) begin
                    ctrl_lines[i] <= cfg[i].phase_b_level; // R02
                end else begin
                    ctrl_lines[i] <= cfg[i].phase_c_level; // R02 R25
                end
            end
            if (ctrl[CB_WIDTH]) begin
                dout_bus.data <= word[part[0]*16 +: 16]; // R21 R12
                low_byte_sel  <= 1'b1;
                high_byte_sel <= 1'b1;
            end else begin
                dout_bus.data <= {8'h00, word[part*8 +: 8]}; // R20 R12
                low_byte_sel  <= ~part[0];
                high_byte_sel <= part[0];
            end
            dout_bus.oe <= alt_sync && (st == ST_WRITE ||
                           (!ctrl[CB_EN_DATA] && st != ST_READ)); // R20 R22
            port_irq <= ctrl[CB_IRQ_ALL] &&
                        ((ctrl[CB_IRQ_PUERR] && push_err) ||
                         (ctrl[CB_IRQ_EMPTY] && !held) ||
                         (ctrl[CB_IRQ_FULL] && held)); // R18
        end
    end

    // ==================================================
    // axi4-lite read channel
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                unique case ({s_axi_araddr[5:2], 2'b00})
                    ADDR_TIMING_01: s_axi_rdata <= {cfg[1], cfg[0]};
                    ADDR_TIMING_23: s_axi_rdata <= {cfg[3], cfg[2]};
                    ADDR_CONTROL:   s_axi_rdata <= ctrl;
                    ADDR_STATUS: begin
                        s_axi_rdata              <= 32'h00000000;
                        s_axi_rdata[SB_RD_VALID] <= rd_valid;
                        s_axi_rdata[SB_PU_ERR]   <= push_err;
                        s_axi_rdata[SB_PU_EMPTY] <= !held;
                        s_axi_rdata[SB_PU_FULL]  <= held;
                        s_axi_rdata[SB_PO_EMPTY] <= !held;
                    end
                    ADDR_DATA_OUT:  s_axi_rdata <= word;
                    ADDR_DATA_IN:   s_axi_rdata <= {16'h0000, din_reg}; // R24
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==================================================
    // checks
    property p_idle_level;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_IDLE) |=> (ctrl_lines[0] == $past(cfg[0].quiescent));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level"); // R04

    property p_phase_a;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_WRITE && !parity && cfg[1].even_cycle_allow
         && step < cfg[1].first_switch_step)
        |=> (ctrl_lines[1] == $past(cfg[1].phase_a_level));
    endproperty
    a_phase_a: assert property (p_phase_a) else $error("first level"); // R02

    property p_step_bound;
        @(posedge clk) disable iff (srst)
        (st != ST_IDLE) |-> (step <= step_end);
    endproperty
    a_step_bound: assert property (p_step_bound) else $error("step range"); // R05

    property p_read_clear;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_READ && last_step && !ctrl_wr)
        |=> (!ctrl[CB_RD_START] && st == ST_IDLE);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read start stays"); // R14

    property p_no_read_on_write;
        @(posedge clk) disable iff (srst)
        (st == ST_IDLE && ctrl[CB_WR_EN]) |=> (st != ST_READ);
    endproperty
    a_no_read_on_write: assert property (p_no_read_on_write) else $error("read"); // R17

    property p_capture;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_READ && step == ctrl[4:0])
        |=> (rd_valid && din_reg == $past(din_sync));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed"); // R11

    property p_valid_clear;
        @(posedge clk) disable iff (srst)
        (ce && ctrl_wr && ctrl_new[CB_RD_START] && st == ST_IDLE) |=> !rd_valid;
    endproperty
    a_valid_clear: assert property (p_valid_clear) else $error("valid kept"); // R15

    property p_parity_toggle;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_WRITE && last_step && !ctrl[CB_RES_EVEN])
        |=> (parity != $past(parity));
    endproperty
    a_parity_toggle: assert property (p_parity_toggle) else $error("parity"); // R09

    property p_float_read;
        @(posedge clk) disable iff (srst)
        (ce && st == ST_READ) |=> !dout_bus.oe;
    endproperty
    a_float_read: assert property (p_float_read) else $error("bus driven"); // R22
endmodule

// File: logic/disp_port_pkg.sv
// constants, field positions and carrier types for the display bus port
package disp_port_pkg;
    // ==================================================
    // register byte addresses
    localparam logic [5:0] ADDR_TIMING_01 = 6'h00;
    localparam logic [5:0] ADDR_TIMING_23 = 6'h04;
    localparam logic [5:0] ADDR_CONTROL   = 6'h08;
    localparam logic [5:0] ADDR_STATUS    = 6'h0C;
    localparam logic [5:0] ADDR_DATA_OUT  = 6'h10;
    localparam logic [5:0] ADDR_DATA_IN   = 6'h14;
    // ==================================================
    // reset values
    localparam logic [31:0] TIMING_RESET  = 32'h4AA64AA6;
    localparam logic [31:0] CONTROL_RESET = 32'h0000001F;
    // ==================================================
    // control register fields
    localparam int CB_CLR_PUSH  = 20;
    localparam int CB_EN_DATA   = 19;
    localparam int CB_SHORT     = 18;
    localparam int CB_RES_EVEN  = 17;
    localparam int CB_WR_EN     = 16;
    localparam int CB_RD_START  = 15;
    localparam int CB_MODE_LO   = 13;
    localparam int CB_WIDTH     = 12;
    localparam int CB_IRQ_ALL   = 11;
    localparam int CB_IRQ_PUERR = 9;
    localparam int CB_IRQ_EMPTY = 8;
    localparam int CB_IRQ_FULL  = 5;
    // ==================================================
    // status register fields
    localparam int SB_RD_VALID = 16;
    localparam int SB_PU_ERR   = 11;
    localparam int SB_PU_EMPTY = 10;
    localparam int SB_PU_FULL  = 6;
    localparam int SB_PO_EMPTY = 4;
    // ==================================================
    // timing generator step ends and axi4-lite response codes
    localparam logic [4:0] STEP_END_LONG  = 5'h1F;
    localparam logic [4:0] STEP_END_SHORT = 5'h0F;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // one control line, laid out as its half of a timing register
    typedef struct packed {
        logic       phase_a_level;
        logic       phase_b_level;
        logic       phase_c_level;
        logic [4:0] first_switch_step;
        logic [4:0] second_switch_step;
        logic       even_cycle_allow;
        logic       odd_cycle_allow;
        logic       quiescent;
    } line_cfg_t;

    typedef struct packed {
        logic [15:0] data;
        logic        oe;
    } bus_out_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } port_state_t;
endpackage

// File: testbench/lcd_panel_model.sv
// display panel model: records written bytes, answers reads with a status word
module lcd_panel_model #(
    parameter logic [15:0] STATUS = 16'h3C5A
) (
    input  wire logic                     clk,        // module clock
    input  wire logic [3:0]               ctrl_lines, // control lines from the port
    input  wire disp_port_pkg::bus_out_t dout_bus,   // port data bus and enable
    output logic [15:0]                   din_pins    // data driven back to the port
);
    timeunit 1ns;
    timeprecision 1ns;
    import disp_port_pkg::*;
    logic [15:0] got[$];
    logic        last_strobe = 1'b0;
    initial din_pins = 16'h0000;
    // ==========
    // strobe line 0: bus taken at its fall, status driven while it is high
    always @(posedge clk) begin
        // released bus toggles every cycle so a stale value never reads as data
        din_pins <= (ctrl_lines[0] && !dout_bus.oe) ? STATUS : ~din_pins;
        last_strobe <= ctrl_lines[0];
        if (last_strobe && !ctrl_lines[0] && dout_bus.oe) got.push_back(dout_bus.data);
    end
endmodule

// File: testbench/testbench.sv
// testbench: registers, waveforms, serializer and read cycles of the display port
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import disp_port_pkg::*;
    localparam logic [15:0] STATUS = 16'hC35A;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        alt_sel = 1'b1;
    logic [5:0]  awaddr = 6'h00;
    logic [5:0]  araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, port_irq, lo_sel, hi_sel;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd_val;
    logic [15:0] din_pins;
    logic [3:0]  ctrl_lines;
    bus_out_t    dout_bus;
    int          error_cnt = 0, tests_run = 0, cycles = 0, hi = 0;

    display_bus_output_port DUT (
        .clk(clk), .srst(srst), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .alt_function_select(alt_sel), .din_pins(din_pins), .dout_bus(dout_bus),
        .ctrl_lines(ctrl_lines), .low_byte_sel(lo_sel), .high_byte_sel(hi_sel),
        .port_irq(port_irq));
    lcd_panel_model #(.STATUS(STATUS)) panel (
        .clk(clk), .ctrl_lines(ctrl_lines), .dout_bus(dout_bus), .din_pins(din_pins));

    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ==========
    // bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_val = rdata;
        rready <= 1'b0;
    endtask
    // push one word, then count clocks with line 0 high over the window
    task automatic push(input logic [31:0] d, input int win);
        panel.got.delete();
        hi = 0;
        wr(ADDR_DATA_OUT, d);
        repeat (win) begin
            @(posedge clk);
            hi += int'(ctrl_lines[0]);
        end
    endtask
    // ==========
    // scenarios
    task automatic t_regs();
        rd(ADDR_TIMING_01);
        chk(rd_val, TIMING_RESET);
        rd(ADDR_TIMING_23);
        chk(rd_val, TIMING_RESET);
        rd(6'h18);
        chk(rd_val, 32'h0);
        chk(32'(rresp), 32'(RESP_SLVERR));
    endtask
    task automatic t_write();
        wr(ADDR_CONTROL, 32'h0001_0000);
        push(32'h0000_00A5, 40);
        chk(hi, 10);
        chk(panel.got.size(), 1);
        chk(32'(panel.got[0][7:0]), 32'hA5);
        chk(32'(ctrl_lines), 32'h0);
        chk(32'({lo_sel, hi_sel}), 32'h2);
        wr(ADDR_CONTROL, 32'h0001_4000);
        push(32'h4433_2211, 140);
        chk(hi, 40);
        for (int i = 0; i < 4; i++) chk(32'(panel.got[i][7:0]), 32'h11 * (i + 1));
        wr(ADDR_CONTROL, 32'h0001_3000);
        push(32'hBEEF_1234, 72);
        chk(32'(panel.got[0]), 32'h1234);
        chk(32'(panel.got[1]), 32'hBEEF);
        chk(32'({lo_sel, hi_sel}), 32'h3);
    endtask
    task automatic t_parity();
        wr(ADDR_CONTROL, 32'h0002_0000);
        wr(ADDR_TIMING_01, 32'h4AA6_4AA2);
        wr(ADDR_CONTROL, 32'h0001_2000);
        push(32'h0000_BBAA, 72);
        chk(panel.got.size(), 1);
        chk(32'(panel.got[0][7:0]), 32'hBB);
        wr(ADDR_CONTROL, 32'h0001_0000);
        push(32'h0000_0077, 40);
        chk(panel.got.size(), 0);
        push(32'h0000_0099, 40);
        chk(32'(panel.got[0][7:0]), 32'h99);
    endtask
    task automatic t_short();
        wr(ADDR_TIMING_01, 32'h4AA7_4346);
        wr(ADDR_CONTROL, 32'h0005_0000);
        chk(32'(ctrl_lines), 32'h2);
        push(32'h0000_00F0, 40);
        chk(hi, 5);
        wr(ADDR_TIMING_01, TIMING_RESET);
    endtask
    task automatic t_read(input bit again);
        int n;
        n = 0;
        wr(ADDR_CONTROL, 32'h0000_8010);
        rd(ADDR_STATUS);
        if (again) chk(32'(rd_val[SB_RD_VALID]), 32'h0);
        while (!rd_val[SB_RD_VALID] && n < 50) begin
            rd(ADDR_STATUS);
            n++;
        end
        chk(32'(rd_val[SB_RD_VALID]), 32'h1);
        rd(ADDR_DATA_IN);
        chk(rd_val, {16'h0, STATUS});
        // the read cycle runs on past the capture step; let it finish
        repeat (32) @(posedge clk);
        rd(ADDR_CONTROL);
        chk(32'(rd_val[CB_RD_START]), 32'h0);
        chk(32'(ctrl_lines), 32'h0);
    endtask
    task automatic t_refuse_irq();
        wr(ADDR_CONTROL, 32'h0001_8010);
        hi = 0;
        repeat (64) begin
            @(posedge clk);
            hi += int'(|ctrl_lines);
        end
        chk(hi, 0);
        wr(ADDR_CONTROL, 32'h0000_0900);
        repeat (3) @(posedge clk);
        chk(32'(port_irq), 32'h1);
        wr(ADDR_CONTROL, 32'h0000_0100);
        repeat (3) @(posedge clk);
        chk(32'(port_irq), 32'h0);
        chk(32'(dout_bus.oe), 32'h1);
        wr(ADDR_CONTROL, 32'h0008_0000);
        repeat (2) @(posedge clk);
        chk(32'(dout_bus.oe), 32'h0);
        wr(ADDR_CONTROL, 32'h0000_0000);
        alt_sel <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(dout_bus.oe), 32'h0);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_write();
        t_parity();
        t_short();
        t_read(1'b0);
        t_read(1'b1);
        t_refuse_irq();
        finish_test();
    end
endmodule
